//--- verilog/rcc_pkg.sv
// Shared constants, field layouts and carrier types of the calendar clock register block.
package rcc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on the APB bus
	// ------------------------------------------------------------
	localparam logic [7:0] RCC_OFF_CFG = 8'h00;
	localparam logic [7:0] RCC_OFF_VAL = 8'h04;
	localparam logic [7:0] RCC_OFF_ALCFG = 8'h08;
	localparam logic [7:0] RCC_OFF_ALVAL = 8'h0C;
	localparam logic [7:0] RCC_OFF_PAD = 8'h10;
	localparam logic [7:0] RCC_OFF_KEY = 8'h14;
	localparam logic [7:0] RCC_OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] RCC_OFF_IRQ_MASK = 8'h1C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RCC_CFG_EN_BIT = 15;
	localparam int RCC_CFG_WREN_BIT = 13;
	localparam int RCC_CFG_HALF_BIT = 11;
	localparam int RCC_CFG_OE_BIT = 10;
	localparam int RCC_PTR_LSB = 8;
	localparam int RCC_AL_EN_BIT = 15;
	localparam int RCC_AL_CHIME_BIT = 14;
	localparam int RCC_AL_MASK_LSB = 10;
	localparam int RCC_PAD_SEL_BIT = 1;
	localparam int RCC_IRQ_SEC_BIT = 0;
	localparam int RCC_IRQ_ALARM_BIT = 1;
	localparam int RCC_IRQ_W = 2;

	// ------------------------------------------------------------
	// Pointer codes, unlock keys and calendar values
	// ------------------------------------------------------------
	localparam logic [1:0] RCC_PTR_MINSEC = 2'h0;
	localparam logic [1:0] RCC_PTR_WDHR = 2'h1;
	localparam logic [1:0] RCC_PTR_MTHDY = 2'h2;
	localparam logic [1:0] RCC_PTR_YEAR = 2'h3;
	localparam logic [15:0] RCC_KEY_FIRST = 16'h55AA;
	localparam logic [15:0] RCC_KEY_SECOND = 16'hAA55;
	localparam logic [7:0] RCC_BCD_SEC_MAX = 8'h59;
	localparam logic [7:0] RCC_BCD_HOUR_MAX = 8'h23;
	localparam logic [7:0] RCC_BCD_WDAY_MAX = 8'h06;
	localparam logic [7:0] RCC_BCD_MONTH_MAX = 8'h12;
	localparam logic [7:0] RCC_BCD_YEAR_MAX = 8'h99;
	localparam logic [7:0] RCC_BCD_ONE = 8'h01;
	localparam logic [7:0] RCC_BCD_FEB = 8'h02;
	localparam logic [3:0] RCC_BCD_NINE = 4'h9;

	// ------------------------------------------------------------
	// Timing: half a second at a 50 MHz clock
	// ------------------------------------------------------------
	localparam longint RCC_HALF_SEC_NS = 500000000;
	localparam longint RCC_CLK_PERIOD_NS = 20;
	localparam int RCC_HALF_SEC_CYCLES = int'(RCC_HALF_SEC_NS / RCC_CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rcc_time_type;

	typedef struct packed {
		logic enable;
		logic chime;
		logic [3:0] mask;
		logic [1:0] ptr;
		logic [7:0] repeat_cnt;
	} rcc_alcfg_type;

endpackage : rcc_pkg

//--- verilog/rcc_calendar_clock.sv
// Calendar clock core with APB register windows, write lock and clock output pin.
`timescale 1ns/1ns

// Function
// - Keep hours, minutes, seconds at half-second resolution.
// - Weekday and leap years for 2000 to 2099.
// - All time and date fields in BCD.
// - Hours presented in 24-hour format.
// - Source select one gives seconds, zero alarm.
// - Output pin driven only with output enable set.
// - Calendar keeps counting through pin reset.
// - Value pointer selects the time field pair.
// - High byte write decrements value pointer, stops 00.
// - At 00 stay on minutes and seconds.
// - Alarm pointer selects the alarm field pair.
// - Alarm high write decrements pointer, stops 00.
// - Window reads decrement; low writes do not.
// - Time writes accepted only with write enable.
// - Write enable set only right after unlock.
// - Module enable writable only with write enable.
module rcc_calendar_clock import rcc_pkg::*; #(
	parameter int HALF_SEC_CYCLES = RCC_HALF_SEC_CYCLES
) (
	// Clock and power-on reset.
	input wire logic pclk,
	input wire logic presetn,
	// Pin reset; it does not stop the calendar.
	input wire logic pin_reset,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock output pin and interrupt.
	output logic clock_out,
	output logic clock_out_oe,
	output logic irq
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (HALF_SEC_CYCLES < 2) begin : g_bad_param
		$error("HALF_SEC_CYCLES must be at least 2");
	end

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// BCD increment that wraps from max to the given start value.
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max,
		input logic [7:0] start);
		logic [7:0] r;
		r = v;
		if (v == max) begin
			r = start;
		end else if (v[3:0] == RCC_BCD_NINE) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	// Last day of a month in BCD; every year divisible by four is leap in 2000..2099.
	function automatic logic [7:0] bcd_last_day(input logic [7:0] month, input logic [7:0] year);
		logic [7:0] r;
		logic [1:0] y4;
		y4 = 2'(year[3:0]) + 2'({year[4], 1'b0});
		case (month)
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			RCC_BCD_FEB: r = (y4 == 2'h0) ? 8'h29 : 8'h28;
			default: r = 8'h31;
		endcase
		return r;
	endfunction : bcd_last_day

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rcc_time_type time_q; // Calendar, all fields BCD.
	rcc_time_type alarm_q; // Alarm compare values.
	rcc_alcfg_type alcfg_q; // Alarm configuration.
	logic module_enable_q; // Counting enable.
	logic timer_write_enable_q; // Write lock for time values.
	logic clock_output_enable_q; // Pin enable.
	logic [1:0] value_window_pointer_q; // Time window pointer.
	logic [7:0] calibration_q; // Drift trim, stored only.
	logic output_source_select_q; // Pin source select.
	logic parallel_input_buffer_select_q; // Pad buffer type, stored only.
	logic halfsec_q; // Second half of the current second.
	logic [31:0] prescale_q; // Half-second prescaler.
	logic [1:0] unlock_stage_q; // 0 idle, 1 first key seen, 2 armed.
	logic alarm_pulse_q; // Alarm output level, toggles per event.
	logic [RCC_IRQ_W-1:0] irq_stat_q; // Sticky events.
	logic [RCC_IRQ_W-1:0] irq_mask_q; // Event enables.
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic clock_out_q;
	logic clock_out_oe_q;
	logic irq_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic access; // Access phase, first cycle; the answer follows.
	logic done; // Transfer completes at this edge.
	logic wr;
	logic rd;
	logic mapped;
	logic half_tick; // End of a half second.
	logic sec_tick; // Whole second boundary.
	logic alarm_hit;

	assign access = psel && penable && !pready_q;
	assign done = psel && penable && pready_q;
	assign wr = done && pwrite;
	assign rd = done && !pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= RCC_OFF_IRQ_MASK);
	assign half_tick = module_enable_q && (prescale_q == 32'(HALF_SEC_CYCLES - 1));
	assign sec_tick = half_tick && halfsec_q;

	// ------------------------------------------------------------
	// APB answer: one wait state, every output from a flop
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= access;
			pslverr_q <= access && !mapped;
			if (access && !pwrite) begin
				case (paddr)
					RCC_OFF_CFG: prdata_q <= {16'h0, module_enable_q, 1'b0,
						timer_write_enable_q, 1'b0, halfsec_q, clock_output_enable_q,
						value_window_pointer_q, calibration_q};
					RCC_OFF_VAL: begin
						case (value_window_pointer_q)
							RCC_PTR_MINSEC: prdata_q <= {16'h0, time_q.min, time_q.sec};
							RCC_PTR_WDHR: prdata_q <= {16'h0, time_q.wday, time_q.hour};
							RCC_PTR_MTHDY: prdata_q <= {16'h0, time_q.month, time_q.day};
							default: prdata_q <= {24'h0, time_q.year};
						endcase
					end
					RCC_OFF_ALCFG: prdata_q <= {16'h0, alcfg_q};
					RCC_OFF_ALVAL: begin
						case (alcfg_q.ptr)
							RCC_PTR_MINSEC: prdata_q <= {16'h0, alarm_q.min, alarm_q.sec};
							RCC_PTR_WDHR: prdata_q <= {16'h0, alarm_q.wday, alarm_q.hour};
							RCC_PTR_MTHDY: prdata_q <= {16'h0, alarm_q.month, alarm_q.day};
							default: prdata_q <= 32'h0;
						endcase
					end
					RCC_OFF_PAD: prdata_q <= {30'h0, output_source_select_q,
						parallel_input_buffer_select_q};
					RCC_OFF_KEY: prdata_q <= {30'h0, unlock_stage_q};
					RCC_OFF_IRQ_STAT: prdata_q <= {30'h0, irq_stat_q};
					RCC_OFF_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
					default: prdata_q <= 32'h0;
				endcase
			end else begin
				prdata_q <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------
	// Any completed transfer other than the expected key drops the sequence, so the
	// armed state lives for exactly one following transfer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_stage_q <= 2'h0;
		end else if (pin_reset) begin
			unlock_stage_q <= 2'h0;
		end else if (done) begin
			if (wr && paddr == RCC_OFF_KEY && pwdata[15:0] == RCC_KEY_FIRST) begin
				unlock_stage_q <= 2'h1;
			end else if (wr && paddr == RCC_OFF_KEY && pwdata[15:0] == RCC_KEY_SECOND
				&& unlock_stage_q == 2'h1) begin
				unlock_stage_q <= 2'h2;
			end else begin
				unlock_stage_q <= 2'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// Only power-on reset touches this register, as the clock must survive pin reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_enable_q <= 1'b0;
			timer_write_enable_q <= 1'b0;
			clock_output_enable_q <= 1'b0;
			calibration_q <= 8'h0;
		end else if (wr && paddr == RCC_OFF_CFG) begin
			clock_output_enable_q <= pwdata[RCC_CFG_OE_BIT];
			calibration_q <= pwdata[7:0];
			if (timer_write_enable_q) begin
				module_enable_q <= pwdata[RCC_CFG_EN_BIT];
			end
			if (!pwdata[RCC_CFG_WREN_BIT]) begin
				timer_write_enable_q <= 1'b0; // Clearing is always allowed.
			end else if (unlock_stage_q == 2'h2) begin
				timer_write_enable_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Value window pointer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_window_pointer_q <= RCC_PTR_MINSEC;
		end else if (wr && paddr == RCC_OFF_CFG) begin
			value_window_pointer_q <= pwdata[RCC_PTR_LSB +: 2];
		end else if (paddr == RCC_OFF_VAL && (rd || (wr && pstrb[1]))) begin
			if (value_window_pointer_q != RCC_PTR_MINSEC) begin
				value_window_pointer_q <= value_window_pointer_q - 2'h1;
			end // At 00 the pointer parks on minutes and seconds.
		end
	end

	// ------------------------------------------------------------
	// Half-second prescaler
	// ------------------------------------------------------------
	// Writing the seconds byte restarts the second, clearing the half flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= 32'h0;
			halfsec_q <= 1'b0;
		end else if (wr && paddr == RCC_OFF_VAL && pstrb[0] && timer_write_enable_q
			&& value_window_pointer_q == RCC_PTR_MINSEC) begin
			prescale_q <= 32'h0;
			halfsec_q <= 1'b0;
		end else if (half_tick) begin
			prescale_q <= 32'h0;
			halfsec_q <= !halfsec_q;
		end else if (module_enable_q) begin
			prescale_q <= prescale_q + 32'h1; // pin_reset not used here.
		end
	end

	// ------------------------------------------------------------
	// Calendar counters and time writes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_q <= '{year: 8'h0, month: RCC_BCD_ONE, day: RCC_BCD_ONE, wday: 8'h06,
				hour: 8'h0, min: 8'h0, sec: 8'h0};
		end else if (wr && paddr == RCC_OFF_VAL) begin
			if (timer_write_enable_q) begin
				case (value_window_pointer_q)
					RCC_PTR_MINSEC: begin
						if (pstrb[1]) time_q.min <= pwdata[15:8];
						if (pstrb[0]) time_q.sec <= pwdata[7:0];
					end
					RCC_PTR_WDHR: begin
						if (pstrb[1]) time_q.wday <= pwdata[15:8];
						if (pstrb[0]) time_q.hour <= pwdata[7:0];
					end
					RCC_PTR_MTHDY: begin
						if (pstrb[1]) time_q.month <= pwdata[15:8];
						if (pstrb[0]) time_q.day <= pwdata[7:0];
					end
					default: begin
						if (pstrb[0]) time_q.year <= pwdata[7:0];
					end
				endcase
			end
		end else if (sec_tick) begin
			// Ripple carry through the fields, 24-hour clock.
			time_q.sec <= bcd_inc(time_q.sec, RCC_BCD_SEC_MAX, 8'h0);
			if (time_q.sec == RCC_BCD_SEC_MAX) begin
				time_q.min <= bcd_inc(time_q.min, RCC_BCD_SEC_MAX, 8'h0);
				if (time_q.min == RCC_BCD_SEC_MAX) begin
					time_q.hour <= bcd_inc(time_q.hour, RCC_BCD_HOUR_MAX, 8'h0);
					if (time_q.hour == RCC_BCD_HOUR_MAX) begin
						time_q.wday <= bcd_inc(time_q.wday, RCC_BCD_WDAY_MAX, 8'h0);
						time_q.day <= bcd_inc(time_q.day,
							bcd_last_day(time_q.month, time_q.year), RCC_BCD_ONE);
						if (time_q.day == bcd_last_day(time_q.month, time_q.year)) begin
							time_q.month <= bcd_inc(time_q.month, RCC_BCD_MONTH_MAX, RCC_BCD_ONE);
							if (time_q.month == RCC_BCD_MONTH_MAX) begin
								time_q.year <= bcd_inc(time_q.year, RCC_BCD_YEAR_MAX, 8'h0);
							end
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Alarm match
	// ------------------------------------------------------------
	// Wider masks compare more fields, but 8 compares the day in place of the weekday of 7; reserved codes never match.
	always_comb begin
		alarm_hit = 1'b0;
		case (alcfg_q.mask)
			4'h0: alarm_hit = half_tick;
			4'h1: alarm_hit = sec_tick;
			4'h2: alarm_hit = sec_tick && time_q.sec[3:0] == alarm_q.sec[3:0];
			4'h3: alarm_hit = sec_tick && time_q.sec == alarm_q.sec;
			4'h4: alarm_hit = sec_tick && time_q.sec == alarm_q.sec
				&& time_q.min[3:0] == alarm_q.min[3:0];
			4'h5: alarm_hit = sec_tick && time_q[15:0] == alarm_q[15:0];
			4'h6: alarm_hit = sec_tick && time_q[23:0] == alarm_q[23:0];
			4'h7: alarm_hit = sec_tick && time_q[31:0] == alarm_q[31:0];
			4'h8: alarm_hit = sec_tick && time_q[23:0] == alarm_q[23:0]
				&& time_q.day == alarm_q.day;
			4'h9: alarm_hit = sec_tick && time_q[23:0] == alarm_q[23:0]
				&& time_q.day == alarm_q.day && time_q.month == alarm_q.month;
			default: alarm_hit = 1'b0;
		endcase
		alarm_hit = alarm_hit && alcfg_q.enable;
	end

	// ------------------------------------------------------------
	// Alarm configuration, pointer and values
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alcfg_q <= '0;
			alarm_q <= '0;
		end else if (wr && paddr == RCC_OFF_ALCFG) begin
			alcfg_q <= pwdata[15:0];
		end else begin
			if (wr && paddr == RCC_OFF_ALVAL) begin
				case (alcfg_q.ptr)
					RCC_PTR_MINSEC: begin
						if (pstrb[1]) alarm_q.min <= pwdata[15:8];
						if (pstrb[0]) alarm_q.sec <= pwdata[7:0];
					end
					RCC_PTR_WDHR: begin
						if (pstrb[1]) alarm_q.wday <= pwdata[15:8];
						if (pstrb[0]) alarm_q.hour <= pwdata[7:0];
					end
					RCC_PTR_MTHDY: begin
						if (pstrb[1]) alarm_q.month <= pwdata[15:8];
						if (pstrb[0]) alarm_q.day <= pwdata[7:0];
					end
					default: ;
				endcase
			end
			if (paddr == RCC_OFF_ALVAL && (rd || (wr && pstrb[1]))
				&& alcfg_q.ptr != RCC_PTR_MINSEC) begin
				alcfg_q.ptr <= alcfg_q.ptr - 2'h1;
			end
			if (alarm_hit) begin
				if (alcfg_q.repeat_cnt != 8'h0 || alcfg_q.chime) begin
					alcfg_q.repeat_cnt <= alcfg_q.repeat_cnt - 8'h1;
				end else begin
					alcfg_q.enable <= 1'b0; // Last repeat used up.
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pad configuration (cleared by pin reset too)
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_source_select_q <= 1'b0;
			parallel_input_buffer_select_q <= 1'b0;
		end else if (pin_reset) begin
			output_source_select_q <= 1'b0;
			parallel_input_buffer_select_q <= 1'b0;
		end else if (wr && paddr == RCC_OFF_PAD) begin
			output_source_select_q <= pwdata[RCC_PAD_SEL_BIT];
			parallel_input_buffer_select_q <= pwdata[0];
		end
	end

	// ------------------------------------------------------------
	// Clock output pin
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_pulse_q <= 1'b0;
			clock_out_q <= 1'b0;
			clock_out_oe_q <= 1'b0;
		end else begin
			if (alarm_hit) begin
				alarm_pulse_q <= !alarm_pulse_q;
			end
			// Seconds clock is high in the first half of each second.
			clock_out_q <= clock_output_enable_q
				&& (output_source_select_q ? !halfsec_q : alarm_pulse_q);
			clock_out_oe_q <= clock_output_enable_q;
		end
	end

	// ------------------------------------------------------------
	// Interrupts: sticky, write one to clear, a new event wins
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_q <= 1'b0;
		end else if (pin_reset) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (wr && paddr == RCC_OFF_IRQ_MASK) begin
				irq_mask_q <= pwdata[RCC_IRQ_W-1:0];
			end
			irq_stat_q <= (irq_stat_q & ~((wr && paddr == RCC_OFF_IRQ_STAT)
				? pwdata[RCC_IRQ_W-1:0] : '0))
				| {alarm_hit, sec_tick};
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign clock_out = clock_out_q;
	assign clock_out_oe = clock_out_oe_q;
	assign irq = irq_q;

endmodule : rcc_calendar_clock

//--- tb/rcc_calendar_clock_sva.sv
// Port-level checker of the calendar clock register block.
`timescale 1ns/1ns
module rcc_calendar_clock_sva import rcc_pkg::*; #(
	parameter int HALF_SEC_CYCLES = 4
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bus side.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pin side.
	input wire logic clock_out,
	input wire logic clock_out_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The answer comes exactly one cycle after the access phase and stands one cycle.
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready missing after access");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	ready_cause_a: assert property (!(psel && penable) |=> !pready)
		else $error("ready without access");
	// Only unaligned or out-of-map addresses are refused.
	err_decode_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0
		|| paddr > RCC_OFF_IRQ_MASK)) else $error("error flag wrong for address");
	err_alone_a: assert property (pslverr |-> pready) else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data idle");
	// The pin enable follows the configuration bit two cycles after the answer.
	oe_set_a: assert property (pready && pwrite && paddr == RCC_OFF_CFG && pwdata[10]
		|-> ##2 clock_out_oe) else $error("output enable not set");
	oe_clear_a: assert property (pready && pwrite && paddr == RCC_OFF_CFG && !pwdata[10]
		|-> ##2 !clock_out_oe) else $error("output enable not cleared");
	// A disabled pin never carries a level, whichever source is selected.
	out_gated_a: assert property (!clock_out_oe && !$past(clock_out_oe) |-> !clock_out)
		else $error("pin driven while disabled");
endmodule : rcc_calendar_clock_sva

bind rcc_calendar_clock rcc_calendar_clock_sva #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.clock_out(clock_out), .clock_out_oe(clock_out_oe));

//--- tb/calendar_clock_register_window_test.sv
// Self-checking bench of the calendar clock register block.
`timescale 1ns/1ns
module calendar_clock_register_window_test import rcc_pkg::*;;
	// Short half second keeps the run brief: one second is 100 cycles.
	localparam int HALF = 50;
	typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} rcc_note_type;
	logic pclk, presetn, pin_reset, psel, penable, pwrite, pready, pslverr;
	logic clock_out, clock_out_oe, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, cnt;
	logic [3:0] pstrb;
	rcc_note_type exp_q[$];
	rcc_note_type note;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] yi [3] = '{8'h24, 8'h23, 8'h99};
	logic [7:0] yo [3] = '{8'h24, 8'h23, 8'h00};
	logic [15:0] mi [3] = '{16'h0228, 16'h0228, 16'h1231};
	logic [15:0] mo [3] = '{16'h0229, 16'h0301, 16'h0101};

	rcc_calendar_clock #(.HALF_SEC_CYCLES(HALF)) dut_u (.pclk(pclk), .presetn(presetn),
		.pin_reset(pin_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clock_out(clock_out), .clock_out_oe(clock_out_oe), .irq(irq));

	// -----------------------------------------------
	// Checking and bus tasks
	// -----------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// One APB transfer; the expected answer is noted before the request goes out.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] m, input logic e);
		exp_q.push_back({e, m, d & m});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pstrb <= s;
		pwdata <= wr ? d : $urandom;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF, 32'h0, 1'b0);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, 4'hF, m, 1'b0);
	endtask : rd

	task unlock;
		wr(RCC_OFF_KEY, {16'h0, RCC_KEY_FIRST});
		wr(RCC_OFF_KEY, {16'h0, RCC_KEY_SECOND});
	endtask : unlock

	task summarize;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// The monitor takes the oldest note whenever an answer stands on the bus.
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			note = exp_q.pop_front();
			check({31'h0, pslverr}, {31'h0, note.err});
			check(prdata & note.mask, note.data);
		end
	end

	// A hang ends the run as a failure.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 12000) begin
			n_mismatch++;
			summarize();
		end
	end

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// -----------------------------------------------
	// Main sequence
	// -----------------------------------------------
	initial begin
		logic [7:0] cal;
		{presetn, pin_reset, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(32'h103B));
		cal = 8'($urandom);
		@(posedge pclk);
		rd(RCC_OFF_CFG, 32'h0, 32'hFFFFFFFF);
		rd(RCC_OFF_VAL, 32'h0, 32'hFFFF);
		apb(1'b0, 8'h20, 32'h0, 4'hF, 32'h0, 1'b1);
		apb(1'b1, 8'h02, 32'h0, 4'hF, 32'h0, 1'b1);
		// Locked: neither module enable nor write enable may be set.
		wr(RCC_OFF_CFG, 32'hA000);
		rd(RCC_OFF_CFG, 32'h0, 32'hA000);
		// An access between the two keys aborts the unlock.
		wr(RCC_OFF_KEY, {16'h0, RCC_KEY_FIRST});
		rd(RCC_OFF_KEY, 32'h1, 32'h3);
		wr(RCC_OFF_KEY, {16'h0, RCC_KEY_SECOND});
		wr(RCC_OFF_CFG, 32'h2000);
		rd(RCC_OFF_CFG, 32'h0, 32'h2000);
		unlock();
		wr(RCC_OFF_CFG, {16'h0, 8'h23, cal});
		rd(RCC_OFF_CFG, {16'h0, 8'h23, cal}, 32'hFFFFF7FF);
		// Two seconds before midnight, across leap, non-leap and century ends.
		for (int i = 0; i < 3; i++) begin
			wr(RCC_OFF_CFG, 32'h2300);
			apb(1'b1, RCC_OFF_VAL, {24'h0, yi[i]}, 4'h3, 32'h0, 1'b0);
			apb(1'b1, RCC_OFF_VAL, {16'h0, mi[i]}, 4'h3, 32'h0, 1'b0);
			apb(1'b1, RCC_OFF_VAL, 32'h0623, 4'h3, 32'h0, 1'b0);
			apb(1'b1, RCC_OFF_VAL, 32'h5958, 4'h3, 32'h0, 1'b0);
			wr(RCC_OFF_CFG, 32'hA300);
			repeat (125) @(posedge pclk);
			pin_reset <= (i == 0);
			@(posedge pclk);
			pin_reset <= 1'b0;
			repeat (124) @(posedge pclk);
			wr(RCC_OFF_CFG, 32'h2300);
			rd(RCC_OFF_VAL, {24'h0, yo[i]}, 32'hFF);
			rd(RCC_OFF_VAL, {16'h0, mo[i]}, 32'hFFFF);
			rd(RCC_OFF_VAL, 32'h0000, 32'hFFFF);
			rd(RCC_OFF_VAL, 32'h0000, 32'hFFFF);
			rd(RCC_OFF_VAL, 32'h0000, 32'hFFFF);
		end
		// Write lock, and which accesses move the pointer.
		wr(RCC_OFF_CFG, 32'h0300);
		apb(1'b1, RCC_OFF_VAL, 32'h0055, 4'h1, 32'h0, 1'b0);
		rd(RCC_OFF_CFG, 32'h0300, 32'h0300);
		apb(1'b1, RCC_OFF_VAL, 32'h0055, 4'h3, 32'h0, 1'b0);
		rd(RCC_OFF_CFG, 32'h0200, 32'h0300);
		wr(RCC_OFF_CFG, 32'h0300);
		rd(RCC_OFF_VAL, 32'h0, 32'hFF);
		rd(RCC_OFF_CFG, 32'h0200, 32'h0300);
		// Alarm window: high writes and reads walk the pointer down, then it parks at 00.
		wr(RCC_OFF_ALCFG, 32'h0200);
		wr(RCC_OFF_ALVAL, 32'h1231);
		wr(RCC_OFF_ALVAL, 32'h0405);
		wr(RCC_OFF_ALVAL, 32'h3030);
		wr(RCC_OFF_ALCFG, 32'h0200);
		rd(RCC_OFF_ALVAL, 32'h1231, 32'hFFFF);
		rd(RCC_OFF_ALVAL, 32'h0405, 32'hFFFF);
		rd(RCC_OFF_ALVAL, 32'h3030, 32'hFFFF);
		rd(RCC_OFF_ALCFG, 32'h0, 32'h0300);
		// Chime with a once-a-second mask keeps the alarm level toggling for the pin test.
		wr(RCC_OFF_ALCFG, 32'hC400);
		// Pin source and enable: a full-period count of the seconds clock.
		unlock();
		wr(RCC_OFF_CFG, 32'h2000);
		for (int j = 0; j < 3; j++) begin
			wr(RCC_OFF_PAD, {30'h0, j != 1, 1'b0});
			wr(RCC_OFF_CFG, (j == 2) ? 32'hA000 : 32'hA400);
			repeat (3) @(posedge pclk);
			cnt = 32'h0;
			repeat (4 * 2 * HALF) begin
				@(posedge pclk);
				cnt = cnt + {31'h0, clock_out};
			end
			check(cnt, (j == 2) ? 32'h0 : 32'(4 * HALF));
		end
		// Second tick: sticky, masked, unmasked, then cleared by a one.
		wr(RCC_OFF_CFG, 32'h2000);
		rd(RCC_OFF_IRQ_STAT, 32'h3, 32'h3);
		check({31'h0, irq}, 32'h0);
		wr(RCC_OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		wr(RCC_OFF_IRQ_STAT, 32'h3);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		rd(RCC_OFF_IRQ_STAT, 32'h0, 32'h3);
		repeat (5) @(posedge pclk);
		summarize();
	end
endmodule : calendar_clock_register_window_test
